//--- rtl/lpcf_pkg.sv
//
// Purpose: constants, types and lane decoding shared by the packet framer
// Assumes: link widths coded on a 3-bit input, qualifier codes per doubleword
// Notes:   all slicing helpers take the coded width and a bit-time index
//
package lpcf_pkg;

  // ***************************************
  // link widths and geometry
  // ***************************************
  localparam logic [2:0] WID_2      = 3'h0;
  localparam logic [2:0] WID_4      = 3'h1;
  localparam logic [2:0] WID_8      = 3'h2;
  localparam logic [2:0] WID_16     = 3'h3;
  localparam logic [2:0] WID_32     = 3'h4;
  localparam int         DW_BITS    = 32;
  localparam int         CTL_LANES  = 4;
  localparam int         SYNC_FLOPS = 2;
  localparam int         MIN_CMD_GAP = 4;

  // ***************************************
  // doubleword kinds and qualifier codes
  // ***************************************
  localparam logic [2:0] KIND_CMD        = 3'h0;
  localparam logic [2:0] KIND_INS        = 3'h1;
  localparam logic [2:0] KIND_CRC_DATA   = 3'h2;
  localparam logic [2:0] KIND_CRC_NODATA = 3'h3;
  localparam logic [2:0] KIND_DATA       = 3'h4;
  localparam logic [3:0] QUAL_CMD        = 4'hf;
  localparam logic [3:0] QUAL_INS        = 4'h7;
  localparam logic [3:0] QUAL_CRC_DATA   = 4'hc;
  localparam logic [3:0] QUAL_CRC_NODATA = 4'h3;
  localparam logic [3:0] QUAL_DATA       = 4'h0;
  localparam logic [3:0] QUAL_ALL        = 4'hf;
  localparam logic [31:0] IDLE_WORD      = 32'h0000_0000;

  // ***************************************
  // state machines
  // ***************************************
  typedef enum logic [2:0] {
    TX_TRAIN = 3'b001,
    TX_SYNC  = 3'b010,
    TX_RUN   = 3'b100
  } lpcf_tx_state_t;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_SYNC = 3'b010,
    RX_RUN  = 3'b100
  } lpcf_rx_state_t;

  // ***************************************
  // width decoding
  // ***************************************
  function automatic logic [5:0] lpcf_lane_bits(input logic [2:0] w);
    case (w)
      WID_2:   return 6'h02;
      WID_4:   return 6'h04;
      WID_16:  return 6'h10;
      WID_32:  return 6'h20;
      default: return 6'h08;
    endcase
  endfunction

  function automatic logic [4:0] lpcf_bt_per_dw(input logic [2:0] w);
    case (w)
      WID_2:   return 5'h10;
      WID_4:   return 5'h08;
      WID_16:  return 5'h02;
      WID_32:  return 5'h01;
      default: return 5'h04;
    endcase
  endfunction

  function automatic logic [31:0] lpcf_lane_mask(input logic [2:0] w);
    case (w)
      WID_2:   return 32'h0000_0003;
      WID_4:   return 32'h0000_000f;
      WID_16:  return 32'h0000_ffff;
      WID_32:  return 32'hffff_ffff;
      default: return 32'h0000_00ff;
    endcase
  endfunction

  function automatic logic [3:0] lpcf_ctl_mask(input logic [2:0] w);
    case (w)
      WID_16:  return 4'h3;
      WID_32:  return 4'hf;
      default: return 4'h1;
    endcase
  endfunction

  // byte index of a bit-time inside the doubleword (links up to 8 bits)
  function automatic logic [1:0] lpcf_byte_idx(input logic [4:0] idx, input logic [2:0] w);
    case (w)
      WID_2:   return idx[3:2];
      WID_4:   return idx[2:1];
      default: return idx[1:0];
    endcase
  endfunction

  // bit offset of a bit-time inside the doubleword
  function automatic logic [4:0] lpcf_bit_ofs(input logic [4:0] idx, input logic [2:0] w);
    logic [9:0] prod;
    prod = 10'(idx) * 10'(lpcf_lane_bits(w));
    return prod[4:0];
  endfunction

  function automatic logic wide_link(input logic [2:0] w);
    return (w == WID_16) || (w == WID_32);
  endfunction

endpackage

//--- rtl/lpcf_framer.sv
//
// Purpose: packet framer for a point-to-point link, transmit and receive
// Assumes: link clock sampled by clk, at least four clk cycles per link half period
// Notes:   tx launches on link clock fall, rx samples on link clock rise
`timescale 1ns/1ps

// ***************************************
// two-entry buffer
// ***************************************
module lpcf_buf2 #(
  parameter int WIDTH = 35
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wrPtr_r;
  logic             rdPtr_r;
  logic [1:0]       count_r;
  logic             push;
  logic             pop;

  // handshake terms
  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_r[rdPtr_r];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) wrPtr_r <= ~wrPtr_r;
      if (pop) rdPtr_r <= ~rdPtr_r;
      count_r <= 2'(count_r + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule

// ***************************************
// framer top
// ***************************************
module lpcf_framer
  import lpcf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // configuration, held between link initializations
  input  wire logic [2:0]  linkWidth,
  input  wire logic        laterMode,
  input  wire logic        cmdInsertEnable,
  input  wire logic        cmdThrottleDisable,
  input  wire logic        linkTrainDone,
  input  wire logic        linkDisconnect,
  // link pins
  input  wire logic        linkClk,
  output logic [31:0]      txCad,
  output logic [3:0]       txCtl,
  input  wire logic [31:0] rxCad,
  input  wire logic [3:0]  rxCtl,
  // transmit doublewords from user logic
  input  wire logic        txValid,
  output logic             txReady,
  input  wire logic [31:0] txData,
  input  wire logic [2:0]  txKind,
  // received doublewords to user logic
  output logic             rxValid,
  input  wire logic        rxReady,
  output logic [31:0]      rxData,
  output logic [2:0]       rxKind,
  // status
  output logic             linkAligned,
  output logic             rxFrameError,
  output logic             rxOverrun,
  output logic             insertViolation,
  output logic             throttleViolation
);
  logic [1:0]     rstSync_r;
  logic           rstN;
  logic [1:0]     lclkSync_r;
  logic           lclkPrev_r;
  logic [31:0]    cadSync1_r, cadSync2_r;
  logic [3:0]     ctlSync1_r, ctlSync2_r;
  logic           linkRise, linkFall;
  logic [4:0]     btPerDw;
  logic [31:0]    laneMask;
  logic           linkUp;

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rstSync_r <= 2'h0;
    else          rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  // link pins pass two flops before use
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lclkSync_r <= 2'h0;
      lclkPrev_r <= 1'b0;
      cadSync1_r <= 32'h0;
      cadSync2_r <= 32'h0;
      ctlSync1_r <= 4'h0;
      ctlSync2_r <= 4'h0;
    end else begin
      lclkSync_r <= {lclkSync_r[0], linkClk};
      lclkPrev_r <= lclkSync_r[1];
      cadSync1_r <= rxCad;
      cadSync2_r <= cadSync1_r;
      ctlSync1_r <= rxCtl;
      ctlSync2_r <= ctlSync1_r;
    end
  end

  assign linkRise = lclkSync_r[1] && !lclkPrev_r;
  assign linkFall = !lclkSync_r[1] && lclkPrev_r;
  assign btPerDw  = lpcf_bt_per_dw(linkWidth);
  assign laneMask = lpcf_lane_mask(linkWidth);
  assign linkUp   = linkTrainDone && !linkDisconnect;

  // ***************************************
  // transmit path
  // ***************************************
  lpcf_tx_state_t txState_r;
  logic           txBufValid;
  logic           txBufReady;
  logic [34:0]    txBufData;
  logic [4:0]     txIdx_r;
  logic [31:0]    txWord_r;
  logic [3:0]     txQual_r;
  logic           txInsSeen_r;
  logic           txInData_r;
  logic           txStart;
  logic [31:0]    txWordNow;
  logic [3:0]     txQualNow;
  logic [3:0]     txQualNew;
  logic [2:0]     txKindNew;
  logic [4:0]     txIdxNow;
  logic [4:0]     txIdxNxt;

  lpcf_buf2 #(.WIDTH(35)) txBuf (
    .clk      (clk),
    .rstN     (rstN),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   ({txKind, txData}),
    .outValid (txBufValid),
    .outReady (txBufReady),
    .outData  (txBufData)
  );

  // a doubleword is taken only at a dword boundary in the run state
  assign txStart    = (txState_r == TX_RUN) && linkFall && (txIdx_r == 5'h0);
  assign txBufReady = txStart;
  assign txKindNew  = txBufValid ? txBufData[34:32] : (txInData_r ? KIND_INS : KIND_CMD);
  assign txIdxNow   = txIdx_r;
  assign txIdxNxt   = (txIdx_r == 5'(btPerDw - 5'h1)) ? 5'h0 : 5'(txIdx_r + 5'h1);

  // qualifier code for the new doubleword
  always_comb begin
    case (txKindNew)
      KIND_INS:        txQualNew = txInsSeen_r ? QUAL_CMD : QUAL_INS;
      KIND_CRC_DATA:   txQualNew = QUAL_CRC_DATA;
      KIND_CRC_NODATA: txQualNew = QUAL_CRC_NODATA;
      KIND_DATA:       txQualNew = QUAL_DATA;
      default:         txQualNew = QUAL_CMD;
    endcase
    if (!laterMode) begin
      txQualNew = (txKindNew == KIND_DATA) ? 4'h0 : QUAL_ALL;
    end
  end

  assign txWordNow = txStart ? (txBufValid ? txBufData[31:0] : IDLE_WORD) : txWord_r;
  assign txQualNow = txStart ? txQualNew : txQual_r;

  // state, bit-time index and insertion tracking
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txState_r   <= TX_TRAIN;
      txIdx_r     <= 5'h0;
      txWord_r    <= 32'h0;
      txQual_r    <= 4'h0;
      txInsSeen_r <= 1'b0;
      txInData_r  <= 1'b0;
    end else if (!linkUp) begin
      txState_r   <= TX_TRAIN;
      txIdx_r     <= 5'h0;
      txInsSeen_r <= 1'b0;
      txInData_r  <= 1'b0;
    end else if (linkFall) begin
      case (txState_r)
        TX_TRAIN: begin
          txState_r <= TX_SYNC; // the 1-to-0 fall opens dword alignment
          txIdx_r   <= (btPerDw == 5'h1) ? 5'h0 : 5'h1;
          if (btPerDw == 5'h1) txState_r <= TX_RUN;
        end
        TX_SYNC: begin
          txIdx_r <= txIdxNxt;
          if (txIdxNxt == 5'h0) txState_r <= TX_RUN;
        end
        default: begin
          txIdx_r  <= txIdxNxt;
          txWord_r <= txWordNow;
          txQual_r <= txQualNow;
          if (txStart) begin
            // idle fill after data is an inserted command, data resumes later
            txInsSeen_r <= (txKindNew == KIND_INS) && txBufValid;
            if (txKindNew == KIND_DATA) txInData_r <= 1'b1;
            else if (txKindNew == KIND_CRC_DATA || txKindNew == KIND_CMD) txInData_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // pin drivers: ones while training, zeros in the sync dword
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txCad <= 32'h0;
      txCtl <= 4'h0;
    end else if (txState_r == TX_TRAIN && !(linkUp && linkFall)) begin
      txCad <= laneMask;
      txCtl <= lpcf_ctl_mask(linkWidth);
    end else if (txState_r != TX_RUN) begin
      txCad <= 32'h0;
      txCtl <= 4'h0;
    end else if (linkFall) begin
      // low bits first on narrow links, earliest byte low on wide links
      txCad <= (txWordNow >> lpcf_bit_ofs(txIdxNow, linkWidth)) & laneMask;
      if (wide_link(linkWidth)) begin
        // lanes of the current bit-time: two bytes per step on 16 bits, all four on 32
        txCtl <= (txQualNow >> {txIdxNow[0], 1'b0})
                 & lpcf_ctl_mask(linkWidth);
      end else begin
        txCtl <= {3'h0, txQualNow[lpcf_byte_idx(txIdxNow, linkWidth)]};
      end
    end
  end

  // ***************************************
  // receive path
  // ***************************************
  lpcf_rx_state_t rxState_r;
  logic           rxPrevOnes_r;
  logic [4:0]     rxIdx_r;
  logic [4:0]     rxIdxNxt;
  logic [31:0]    rxWord_r;
  logic [3:0]     rxQual_r;
  logic [31:0]    rxWordNxt;
  logic [3:0]     rxQualNxt;
  logic [3:0]     rxCtlIn;
  logic           rxDone;
  logic [2:0]     rxKindDec;
  logic           rxCodeOk;
  logic           rxPush;
  logic           rxBufReady;
  logic [34:0]    rxBufOut;
  logic           rxInData_r;
  logic           rxInIns_r;
  logic           rxPrevCmd_r;
  logic [2:0]     rxGap_r;
  logic [2:0]     rxGapAtStart_r;
  logic           rxAllOnes;
  logic           rxAllZero;

  assign rxAllOnes = ((cadSync2_r & laneMask) == laneMask) && ctlSync2_r[0];
  assign rxAllZero = ((cadSync2_r & laneMask) == 32'h0) && !ctlSync2_r[0];
  assign rxIdxNxt  = (rxIdx_r == 5'(btPerDw - 5'h1)) ? 5'h0 : 5'(rxIdx_r + 5'h1);
  assign rxDone    = (rxState_r == RX_RUN) && linkRise && (rxIdxNxt == 5'h0);

  // lanes in: original mode takes its qualifier from lane 0 only
  always_comb begin
    rxCtlIn = laterMode ? (ctlSync2_r & lpcf_ctl_mask(linkWidth))
                        : (ctlSync2_r[0] ? lpcf_ctl_mask(linkWidth) : 4'h0);
    rxWordNxt = ((rxIdx_r == 5'h0) ? 32'h0 : rxWord_r)
              | ((cadSync2_r & laneMask) << lpcf_bit_ofs(rxIdx_r, linkWidth));
    rxQualNxt = (rxIdx_r == 5'h0) ? 4'h0 : rxQual_r;
    if (wide_link(linkWidth)) begin
      rxQualNxt = rxQualNxt | (rxCtlIn << {rxIdx_r[0], 1'b0});
    end else begin
      rxQualNxt[lpcf_byte_idx(rxIdx_r, linkWidth)] = rxCtlIn[0];
    end
  end

  // qualifier decode for a finished doubleword
  always_comb begin
    rxCodeOk = 1'b1;
    if (laterMode) begin
      case (rxQualNxt)
        QUAL_CMD:        rxKindDec = KIND_CMD;
        QUAL_INS:        rxKindDec = KIND_INS;
        QUAL_CRC_DATA:   rxKindDec = KIND_CRC_DATA;
        QUAL_CRC_NODATA: rxKindDec = KIND_CRC_NODATA;
        QUAL_DATA:       rxKindDec = KIND_DATA;
        default: begin
          rxKindDec = KIND_DATA;
          rxCodeOk  = 1'b0;
        end
      endcase
    end else begin
      // a change inside the doubleword is a frame error, the word is dropped and alignment kept
      rxKindDec = (rxQualNxt == QUAL_ALL) ? KIND_CMD : KIND_DATA;
      rxCodeOk  = (rxQualNxt == QUAL_ALL) || (rxQualNxt == 4'h0);
    end
  end

  assign rxPush = rxDone && rxCodeOk;

  lpcf_buf2 #(.WIDTH(35)) rxBuf (
    .clk      (clk),
    .rstN     (rstN),
    .inValid  (rxPush),
    .inReady  (rxBufReady),
    .inData   ({rxKindDec, rxWordNxt}),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxBufOut)
  );
  assign rxData = rxBufOut[31:0];
  assign rxKind = rxBufOut[34:32];

  // hunt for the 1-to-0 fall, then assemble doublewords
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxState_r    <= RX_HUNT;
      rxPrevOnes_r <= 1'b0;
      rxIdx_r      <= 5'h0;
      rxWord_r     <= 32'h0;
      rxQual_r     <= 4'h0;
    end else if (!linkUp) begin
      rxState_r    <= RX_HUNT; // disconnect or retrain drops alignment
      rxPrevOnes_r <= 1'b0;
      rxIdx_r      <= 5'h0;
    end else if (linkRise) begin
      rxPrevOnes_r <= rxAllOnes;
      case (rxState_r)
        RX_HUNT: begin
          if (rxPrevOnes_r && rxAllZero) begin
            rxState_r <= (btPerDw == 5'h1) ? RX_RUN : RX_SYNC;
            rxIdx_r   <= (btPerDw == 5'h1) ? 5'h0 : 5'h1;
          end
        end
        RX_SYNC: begin
          rxIdx_r <= rxIdxNxt;
          if (rxIdxNxt == 5'h0) rxState_r <= RX_RUN;
        end
        default: begin
          rxIdx_r  <= rxIdxNxt;
          rxWord_r <= rxWordNxt;
          rxQual_r <= rxQualNxt;
        end
      endcase
    end
  end

  // insertion and throttle checks on the later-mode stream
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxInData_r        <= 1'b0;
      rxInIns_r         <= 1'b0;
      rxPrevCmd_r       <= 1'b0;
      rxGap_r           <= 3'(MIN_CMD_GAP);
      rxGapAtStart_r    <= 3'(MIN_CMD_GAP);
      insertViolation   <= 1'b0;
      throttleViolation <= 1'b0;
    end else begin
      insertViolation   <= 1'b0;
      throttleViolation <= 1'b0;
      if (!linkUp) begin
        rxInData_r  <= 1'b0;
        rxInIns_r   <= 1'b0;
        rxPrevCmd_r <= 1'b0;
      end else if (rxPush && laterMode) begin
        rxPrevCmd_r <= (rxKindDec == KIND_CMD) || (rxKindDec == KIND_INS);
        if (rxKindDec == KIND_DATA) rxInData_r <= 1'b1;
        if (rxKindDec == KIND_CRC_DATA || rxKindDec == KIND_CRC_NODATA) begin
          rxInData_r <= 1'b0;
          rxInIns_r  <= 1'b0;
        end
        if (rxKindDec == KIND_INS) rxInIns_r <= 1'b1;
        // a new command after data that is not marked inserted
        if (rxKindDec == KIND_CMD && rxInData_r && !rxPrevCmd_r) insertViolation <= 1'b1;
        // a multi-dword insert is not Info and needs the enable
        if (rxKindDec == KIND_CMD && rxInIns_r && rxPrevCmd_r && !cmdInsertEnable) begin
          insertViolation <= 1'b1;
        end
        // command starts: spacing measured in doublewords
        if ((rxKindDec == KIND_CMD || rxKindDec == KIND_INS) && !rxPrevCmd_r) begin
          rxGapAtStart_r <= rxGap_r;
          rxGap_r        <= 3'h1; // counts dwords from this start, start included
        end else if (rxGap_r != 3'(MIN_CMD_GAP)) begin
          rxGap_r <= 3'(rxGap_r + 3'h1);
        end
        // second dword of a command marks it non-Info
        if (rxKindDec == KIND_CMD && rxPrevCmd_r && rxGap_r == 3'h1
            && rxGapAtStart_r < 3'(MIN_CMD_GAP) && !cmdThrottleDisable) begin
          throttleViolation <= 1'b1;
        end
      end
    end
  end

  // status pulses and alignment level
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      linkAligned  <= 1'b0;
      rxFrameError <= 1'b0;
      rxOverrun    <= 1'b0;
    end else begin
      linkAligned  <= (rxState_r == RX_RUN) && (txState_r == TX_RUN);
      rxFrameError <= rxDone && !rxCodeOk;
      rxOverrun    <= rxPush && !rxBufReady; // link cannot stall, word is lost
    end
  end
endmodule

//--- verification/lpcf_framer_sva.sv
// Purpose: port checker for the packet framer
// Assumes: bound to lpcf_framer
// Notes: upCnt_r hides the internal reset release delay
`timescale 1ns/1ps
module lpcf_framer_sva
  import lpcf_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // configuration
  input wire logic [2:0]  linkWidth,
  input wire logic        laterMode,
  input wire logic        linkTrainDone,
  input wire logic        linkDisconnect,
  // link and user sides
  input wire logic [31:0] txCad,
  input wire logic [3:0]  txCtl,
  input wire logic        txReady,
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic [31:0] rxData,
  input wire logic        linkAligned
);
  logic [2:0] upCnt_r;
  wire        up = upCnt_r == 3'h7;
  // cycles since reset release, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      upCnt_r <= 3'h0;
    else if (!up)
      upCnt_r <= upCnt_r + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_train_ones: assert property (
    (up && (!linkTrainDone || linkDisconnect) && linkWidth == WID_8) [*2]
    |=> txCad == 32'h0000_00ff && txCtl == 4'h1) else $error("training lanes wrong");
  a_narrow_lanes: assert property (
    linkAligned && linkWidth == WID_2 |-> txCad[31:2] == 30'h0 && txCtl[3:1] == 3'h0)
    else $error("unused narrow lanes driven");
  a_wide_lanes: assert property (
    linkAligned && linkWidth == WID_16 |-> txCad[31:16] == 16'h0 && txCtl[3:2] == 2'h0)
    else $error("unused wide lanes driven");
  a_orig_qual: assert property (
    linkAligned && !laterMode && linkWidth == WID_32 |-> txCtl inside {4'h0, 4'hf})
    else $error("mixed qualifier in original mode");
  a_later_code: assert property (
    linkAligned && laterMode && linkWidth == WID_32
    |-> txCtl inside {4'hf, 4'h7, 4'hc, 4'h3, 4'h0}) else $error("illegal qualifier code");
  a_stall_hold: assert property (
    rxValid && !rxReady && !linkDisconnect ##1 !linkDisconnect
    |-> rxValid && $stable(rxData)) else $error("stalled word changed");
  a_align_drop: assert property (
    linkDisconnect |-> ##[1:4] !linkAligned) else $error("alignment kept");
  a_ready_back: assert property (
    !txReady |-> ##[1:300] txReady) else $error("tx buffer never drains");
endmodule

//--- verification/lpcf_peer.sv
// Purpose: peer node that replays every bit-time it receives
// Assumes: free running link clock, phase unrelated to clk
// Notes: corrupt breaks qualifier lane 1 to make illegal codes
`timescale 1ns/1ps
module lpcf_peer (
  // fault injection
  input wire logic        corrupt,
  // pins facing the framer
  output logic            linkClk,
  input wire logic [31:0] txCad,
  input wire logic [3:0]  txCtl,
  output logic [31:0]     rxCad,
  output logic [3:0]      rxCtl
);
  logic [31:0] cadHeld = 32'h0;
  logic [3:0]  ctlHeld = 4'h0;
  // bit-time clock, 160 ns period
  initial begin
    linkClk = 1'b0;
    #7;
    forever #80 linkClk = ~linkClk;
  end
  // take each bit-time at the rise, replay it from the next fall, ctl lane 1 flipped while corrupt
  always @(posedge linkClk) begin
    cadHeld <= txCad;
    ctlHeld <= txCtl;
  end
  always @(negedge linkClk) begin
    rxCad <= cadHeld;
    rxCtl <= ctlHeld ^ {2'h0, corrupt, 1'b0};
  end
endmodule

//--- verification/tb.sv
// Purpose: self-checking bench for the framer against an echoing peer
// Assumes: every bit-time comes back one bit-time later
// Notes: zero words of command kinds are idle fillers and are skipped
`timescale 1ns/1ps
module tb;
  import lpcf_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, laterMode = 1'b0, linkTrainDone = 1'b0;
  logic        linkDisconnect = 1'b0, cmdInsertEnable = 1'b0, cmdThrottleDisable = 1'b0;
  logic        txValid = 1'b0, rxReady = 1'b1, corrupt = 1'b0, stall = 1'b0, ok;
  logic [2:0]  linkWidth = WID_8, txKind = KIND_CMD, rxKind, k;
  logic [31:0] txData = 32'h0, txCad, rxCad, rxData;
  logic [3:0]  txCtl, rxCtl;
  logic        linkClk, txReady, rxValid, linkAligned, rxFrameError, rxOverrun;
  logic        insertViolation, throttleViolation;
  logic [2:0]  kinds[4] = '{KIND_CMD, KIND_CRC_DATA, KIND_CRC_NODATA, KIND_DATA};
  logic [34:0] expQ[$];
  int          err_count = 0, tests_run = 0, seed = 32'hbaf0, fe = 0, ov = 0, iv = 0, tv = 0;
  int          base;

  lpcf_framer i_lpcf_framer (.*);
  lpcf_peer   i_lpcf_peer (.*);

  // system clock, 20 ns
  always #10 clk = ~clk;
  // receiver readiness, random unless a stall is ordered
  always @(negedge clk) rxReady <= !stall && ($random(seed) % 4 != 0);

  task automatic check(input bit c, input string msg);
    tests_run++;
    if (!c) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // count status pulses, compare every non-filler word taken from rx
  always @(posedge clk) begin
    fe += int'(rxFrameError === 1'b1);
    ov += int'(rxOverrun === 1'b1);
    iv += int'(insertViolation === 1'b1);
    tv += int'(throttleViolation === 1'b1);
    if (rxValid === 1'b1 && rxReady && !(rxData === 32'h0 && rxKind !== KIND_DATA)) begin
      ok = expQ.size() > 0 && {rxKind, rxData} === expQ[0];
      check(ok, "rx word");
      if (expQ.size() > 0)
        void'(expQ.pop_front());
    end
  end

  // original mode only tells control from data
  function automatic logic [2:0] expKind(input logic [2:0] kd);
    if (laterMode)
      return kd;
    return (kd == KIND_DATA) ? KIND_DATA : KIND_CMD;
  endfunction

  task automatic push(input logic [31:0] d, input logic [2:0] kd, input logic [2:0] e);
    int n;
    n = 0;
    @(negedge clk);
    txValid = 1'b1;
    txData = d;
    txKind = kd;
    while (txReady !== 1'b1 && n < 400) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    check(n < 400, "tx stuck");
    expQ.push_back({e, d});
  endtask

  task automatic drain;
    int n;
    n = 0;
    @(negedge clk) txValid = 1'b0;
    while (expQ.size() != 0 && n < 4000) begin
      n++;
      @(negedge clk);
    end
    check(n < 4000, "rx lost words");
  endtask

  task automatic setup(input logic [2:0] w, input logic m);
    int n;
    n = 0;
    @(negedge clk) linkDisconnect = 1'b1;
    repeat (20) @(negedge clk);
    linkWidth = w;
    laterMode = m;
    cmdInsertEnable = 1'($random(seed));
    cmdThrottleDisable = 1'($random(seed));
    repeat (20) @(negedge clk);
    linkDisconnect = 1'b0;
    while (linkAligned !== 1'b1 && n < 2000) begin
      n++;
      @(negedge clk);
    end
    check(n < 2000, "no alignment");
  endtask

  // later mode sequence with a fixed command tail
  task automatic burst(input logic [2:0] k0, k1, e1, k2, e2);
    push(32'h1, k0, k0);
    push(32'h2, k1, e1);
    push(32'h3, k2, e2);
    push(32'h4, KIND_CMD, KIND_CMD);
    push(32'h5, KIND_CMD, KIND_CMD);
    push(32'h6, KIND_CRC_NODATA, KIND_CRC_NODATA);
    drain();
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (20) @(negedge clk);
    linkTrainDone = 1'b1;
    for (int w = 0; w < 5; w++)
      for (int m = 0; m < 2; m++) begin
        setup(3'(w), 1'(m));
        push(32'hffff_ffff, KIND_DATA, KIND_DATA);
        push(32'h8000_0001, KIND_CRC_DATA, expKind(KIND_CRC_DATA));
        repeat (6) begin
          k = kinds[$unsigned($random(seed)) % 4];
          push(32'($random(seed)) | 32'h1, k, expKind(k));
        end
        drain();
      end
    setup(WID_32, 1'b1);
    @(negedge clk) cmdThrottleDisable = 1'b0;
    base = tv;
    // two-dword command starts two dwords after a command start
    burst(KIND_CRC_NODATA, KIND_CMD, KIND_CMD, KIND_CRC_NODATA, KIND_CRC_NODATA);
    check(tv > base, "close commands passed");
    @(negedge clk) cmdThrottleDisable = 1'b1;
    base = tv;
    burst(KIND_CRC_NODATA, KIND_CMD, KIND_CMD, KIND_CRC_NODATA, KIND_CRC_NODATA);
    check(tv == base, "throttle flagged");
    for (int en = 0; en < 2; en++) begin
      @(negedge clk) cmdInsertEnable = 1'(en);
      base = iv;
      burst(KIND_DATA, KIND_INS, KIND_INS, KIND_INS, KIND_CMD);
      check((iv > base) == (en == 0), "long insert");
    end
    base = iv;
    burst(KIND_DATA, KIND_CMD, KIND_CMD, KIND_CRC_NODATA, KIND_CRC_NODATA);
    check(iv > base, "bare command after data");
    base = ov;
    stall = 1'b1;
    repeat (200) @(negedge clk);
    stall = 1'b0;
    check(ov > base, "no overrun");
    base = fe;
    corrupt = 1'b1;
    repeat (60) @(negedge clk);
    corrupt = 1'b0;
    check(fe > base, "bad code accepted");
    tally_and_finish();
  end

  // tests need about 8k cycles; give up after 75k
  initial begin
    #1_500_000;
    err_count++;
    tally_and_finish();
  end
endmodule

bind lpcf_framer lpcf_framer_sva i_lpcf_framer_sva (.*);
